// *** inc/float_seq_pkg.sv ***
// constants, register map and states of the float mode sequencer
package float_seq_pkg;
  // ======================================================================
  // clock and timing
  localparam int unsigned CLK_HZ            = 10_000_000;
  localparam int unsigned FLOAT_MIN_NS      = 4000;
  localparam int unsigned DUMP_TYP_NS       = 2000;
  localparam int unsigned CLK_NS            = 1_000_000_000 / CLK_HZ;
  localparam int unsigned FLOAT_MIN_CYC     = (FLOAT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned DUMP_TYP_CYC      = DUMP_TYP_NS / CLK_NS;
  localparam int unsigned CNT_W             = 16;

  // ======================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_AFE      = 8'h04;
  localparam logic [7:0] ADDR_CATHODE  = 8'h54;
  localparam logic [7:0] ADDR_T_FLOAT  = 8'h08;
  localparam logic [7:0] ADDR_T_POS    = 8'h0C;
  localparam logic [7:0] ADDR_T_NEG1   = 8'h10;
  localparam logic [7:0] ADDR_T_DUMP   = 8'h14;
  localparam logic [7:0] ADDR_T_NEG2   = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1C;

  // ======================================================================
  // field positions and reset values
  localparam int unsigned CTRL_START_BIT   = 0;
  localparam int unsigned CTRL_FLOAT_BIT   = 1;
  localparam int unsigned CTRL_LED_BIT     = 2;
  localparam int unsigned VREF_LSB         = 4;
  localparam int unsigned VCAT_EN_BIT      = 7;
  localparam int unsigned VCAT_A_LSB       = 8;
  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_HOLD_BIT      = 1;
  localparam int unsigned ST_SHORT_BIT     = 2;
  localparam int unsigned ST_STATE_LSB     = 4;
  localparam logic [1:0]  VREF_0P9         = 2'h2;
  localparam logic [1:0]  VCAT_250MV       = 2'h2;
  localparam logic [31:0] AFE_RESET        = 32'h0000_0020;
  localparam logic [31:0] CATHODE_RESET    = 32'h0000_0000;
  localparam logic [CNT_W-1:0] T_FLOAT_RST = 16'h0028;
  localparam logic [CNT_W-1:0] T_POS_RST   = 16'h0008;
  localparam logic [CNT_W-1:0] T_NEG1_RST  = 16'h0004;
  localparam logic [CNT_W-1:0] T_DUMP_RST  = 16'h0014;
  localparam logic [CNT_W-1:0] T_NEG2_RST  = 16'h0004;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_t;

  typedef enum logic [2:0] {
    S_PRECON,
    S_FLOAT,
    S_INT_CLR,
    S_POS,
    S_NEG,
    S_DUMP,
    S_TAIL,
    S_HOLD
  } seq_state_t;
endpackage

// *** tb/front_end_model.sv ***
// converter side of the analog front end: answers a sample request after a set delay
`timescale 1ns/1ns
module front_end_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       adc_request,
  input  wire logic [7:0] ack_delay,
  output logic            adc_sampled
);
  logic [7:0] wait_q;
  // ======================================================================
  // sample handshake: level stays up until the request is withdrawn
  always_ff @(posedge aclk) begin
    if (!aresetn || !adc_request) begin
      wait_q      <= 8'h00;
      adc_sampled <= 1'b0;
    end else if (wait_q < ack_delay) begin
      wait_q <= wait_q + 8'h01;
    end else begin
      adc_sampled <= 1'b1;
    end
  end
endmodule

// *** tb/test_photodiode_float_sequencer.sv ***
// self-checking bench for the float mode sequencer
`timescale 1ns/1ns
module test_photodiode_float_sequencer;
  import float_seq_pkg::*;
  localparam int TP = 3, TN1 = 2, TN2 = 3, TD = 20;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ack_dly = 8'h01;
  logic [31:0] wdata = 32'h0000_0000, rd;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, adc_sampled;
  logic [1:0]  bresp, rresp, rr, amp_reference_select, cathode_select;
  logic [31:0] rdata;
  logic        pd_connect, amp_input_connect, bpf_bypass, pd_sum_enable, int_reset;
  logic        int_positive, int_negative, int_hold, led_pulse, cathode_override, adc_request;
  int          err_total = 0, n_tests = 0;

  always #50 aclk = ~aclk;

  float_sequencer float_sequencer_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .adc_sampled(adc_sampled), .pd_connect(pd_connect), .amp_input_connect(amp_input_connect),
    .bpf_bypass(bpf_bypass), .pd_sum_enable(pd_sum_enable), .int_reset(int_reset),
    .int_positive(int_positive), .int_negative(int_negative), .int_hold(int_hold),
    .led_pulse(led_pulse), .amp_reference_select(amp_reference_select),
    .cathode_override(cathode_override), .cathode_select(cathode_select),
    .adc_request(adc_request));

  front_end_model front_end_model_i (.aclk(aclk), .aresetn(aresetn),
    .adc_request(adc_request), .ack_delay(ack_dly), .adc_sampled(adc_sampled));

  // ======================================================================
  // comparison, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    d = 32'h0000_0000;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // phase codes rise monotonically through a cycle; 7 is the precondition rest
  function automatic int phase_of();
    if (int_hold) return 6;
    if (int_negative) return pd_connect ? (amp_input_connect ? 4 : 5) : 3;
    if (int_positive) return 2;
    if (int_reset) return 1;
    return pd_connect ? 7 : 0;
  endfunction

  task automatic watch(input int tf, input int dly, input logic led_on);
    int n[8];
    int code, prev, bad_ord, bad_amp, bad_led, leds, bad_req;
    n = '{default: 0};
    prev = 7;
    {bad_ord, bad_amp, bad_led, leds, bad_req} = '0;
    for (int k = 0; k < 3000; k++) begin
      @(negedge aclk);
      code = phase_of();
      if (code == 7 && prev != 7) break;
      if (code != 7 && prev != 7 && code < prev) bad_ord++;
      if (code <= 3 && amp_input_connect) bad_amp++;
      if (led_pulse && code > 3) bad_led++;
      if (led_pulse) leds++;
      if (code == 6 && !adc_request) bad_req++;
      n[code]++;
      prev = code;
    end
    check(32'(n[0] + n[1] + n[2] + n[3]), 32'(tf));
    check(32'(n[1]), 32'd1);
    check(32'(n[2]), 32'(TP));
    check(32'(n[3]), 32'(TN1));
    check(32'(n[4]), 32'(TD));
    check(32'(n[5]), 32'(TN2));
    check(32'(bad_ord), 32'd0);
    check(32'(bad_amp), 32'd0);
    check(32'(bad_led), 32'd0);
    check(32'(leds > 0), 32'(led_on));
    // the request is withdrawn for the last hold cycle, once the sample is seen
    check(32'(bad_req), 32'd1);
    check(32'(n[6] > dly), 32'd1);
  endtask

  // ======================================================================
  // scenarios
  task automatic test_reset();
    check(32'({pd_connect, amp_input_connect, pd_sum_enable}), 32'h0000_0007);
    check(32'({int_hold, led_pulse, adc_request, bpf_bypass}), 32'h0000_0000);
    axi_read(ADDR_AFE, rd, rr);
    check(rd, AFE_RESET);
    axi_read(ADDR_T_DUMP, rd, rr);
    check(rd, 32'(T_DUMP_RST));
    axi_read(8'h40, rd, rr);
    check(32'({rr, rd[3:0]}), 32'({RESP_SLVERR, 4'h0}));
    axi_write(8'h40, 32'h0000_0000);
    check(32'(bresp), 32'(RESP_SLVERR));
    $display("test_reset done");
  endtask

  task automatic test_bias();
    axi_write(ADDR_AFE, 32'h0000_0020);
    @(negedge aclk);
    check(32'(amp_reference_select), 32'(VREF_0P9));
    axi_write(ADDR_CATHODE, 32'h0000_0280);
    @(negedge aclk);
    check(32'({cathode_override, cathode_select}), 32'({1'b1, VCAT_250MV}));
    check(32'(bresp), 32'(RESP_OKAY));
    axi_read(ADDR_CATHODE, rd, rr);
    check(rd, 32'h0000_0280);
    $display("test_bias done");
  endtask

  task automatic test_float_cycle();
    axi_write(ADDR_T_POS, 32'(TP));
    axi_write(ADDR_T_NEG1, 32'(TN1));
    axi_write(ADDR_T_NEG2, 32'(TN2));
    axi_write(ADDR_T_FLOAT, 32'h0000_0050);
    axi_write(ADDR_CTRL, 32'h0000_0007);
    @(negedge aclk);
    check(32'({bpf_bypass, pd_sum_enable}), 32'h0000_0003);
    watch(80, 1, 1'b1);
    axi_read(ADDR_STATUS, rd, rr);
    check(32'(rd[ST_SHORT_BIT]), 32'd0);
    $display("test_float_cycle done");
  endtask

  task automatic test_half_float();
    ack_dly <= 8'h14;
    axi_write(ADDR_T_FLOAT, 32'h0000_0028); // half the previous float time
    axi_write(ADDR_CTRL, 32'h0000_0007);
    watch(40, 20, 1'b1);
    $display("test_half_float done");
  endtask

  task automatic test_short_float();
    axi_write(ADDR_T_FLOAT, 32'h0000_000a);
    axi_write(ADDR_CTRL, 32'h0000_0003);
    watch(40, 20, 1'b0);
    axi_read(ADDR_STATUS, rd, rr);
    check(32'(rd[ST_SHORT_BIT]), 32'd1);
    $display("test_short_float done");
  endtask

  task automatic test_no_float();
    int opened;
    opened = 0;
    axi_write(ADDR_CTRL, 32'h0000_0001);
    repeat (30) begin
      @(negedge aclk);
      if (!pd_connect || int_reset) opened++;
    end
    check(32'({bpf_bypass, opened[7:0]}), 32'h0000_0000);
    $display("test_no_float done");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    test_reset();
    test_bias();
    test_float_cycle();
    test_half_float();
    test_short_float();
    test_no_float();
    print_verdict();
  end

  // a hung handshake or sequence ends the run here
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    print_verdict();
  end
endmodule

// *** verilog/axil_regs.sv ***
// axi4-lite slave with the sequencer's configuration registers
`timescale 1ns/1ns
module axil_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] status,
  output logic             start_pulse,
  output logic [31:0]      ctrl,
  output logic [31:0]      afe,
  output logic [31:0]      cathode,
  output logic [15:0]      t_float,
  output logic [15:0]      t_pos,
  output logic [15:0]      t_neg1,
  output logic [15:0]      t_dump,
  output logic [15:0]      t_neg2
);
  import float_seq_pkg::*;

  logic        aw_have_q;
  logic [7:0]  aw_addr_q;
  logic        w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_AFE || a == ADDR_CATHODE || a == ADDR_T_FLOAT ||
           a == ADDR_T_POS || a == ADDR_T_NEG1 || a == ADDR_T_DUMP ||
           a == ADDR_T_NEG2 || a == ADDR_STATUS;
  endfunction

  // ======================================================================
  // write path: address and data taken in either order
  wire do_write = aw_have_q && w_have_q && !bvalid;
  assign awready = !aw_have_q;
  assign wready  = !w_have_q;
  wire [31:0] t_word = merge({16'h0000, 16'h0000}, w_data_q, w_strb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q   <= 1'b0;
      aw_addr_q   <= 8'h00;
      w_have_q    <= 1'b0;
      w_data_q    <= 32'h0000_0000;
      w_strb_q    <= 4'h0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      start_pulse <= 1'b0;
      ctrl        <= 32'h0000_0000;
      afe         <= AFE_RESET;
      cathode     <= CATHODE_RESET;
      t_float     <= T_FLOAT_RST;
      t_pos       <= T_POS_RST;
      t_neg1      <= T_NEG1_RST;
      t_dump      <= T_DUMP_RST;
      t_neg2      <= T_NEG2_RST;
    end else begin
      start_pulse <= 1'b0;
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        unique case (aw_addr_q)
          ADDR_CTRL: begin
            ctrl        <= merge(ctrl, w_data_q, w_strb_q) & 32'h0000_0006;
            start_pulse <= w_strb_q[0] && w_data_q[CTRL_START_BIT];
          end
          ADDR_AFE:     afe     <= merge(afe, w_data_q, w_strb_q);
          ADDR_CATHODE: cathode <= merge(cathode, w_data_q, w_strb_q);
          ADDR_T_FLOAT: t_float <= t_word[15:0];
          ADDR_T_POS:   t_pos   <= t_word[15:0];
          ADDR_T_NEG1:  t_neg1  <= t_word[15:0];
          ADDR_T_DUMP:  t_dump  <= t_word[15:0];
          ADDR_T_NEG2:  t_neg2  <= t_word[15:0];
          default: ;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ======================================================================
  // read path: one cycle from address to data
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= mapped({araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      unique case ({araddr[7:2], 2'b00})
        ADDR_CTRL:    rdata <= ctrl;
        ADDR_AFE:     rdata <= afe;
        ADDR_CATHODE: rdata <= cathode;
        ADDR_T_FLOAT: rdata <= {16'h0000, t_float};
        ADDR_T_POS:   rdata <= {16'h0000, t_pos};
        ADDR_T_NEG1:  rdata <= {16'h0000, t_neg1};
        ADDR_T_DUMP:  rdata <= {16'h0000, t_dump};
        ADDR_T_NEG2:  rdata <= {16'h0000, t_neg2};
        ADDR_STATUS:  rdata <= status;
        default:      rdata <= 32'h0000_0000;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// *** verilog/float_sequencer.sv ***
// float mode measurement sequencer with axi4-lite configuration
// ======================================================================
// Function
// RULE1: float mode routes the signal around the band-pass filter.
// RULE2: precondition connects photodiode; anode reference select field 0x2 means 0.9 V.
// RULE3: cathode override bit 7 plus cathode field 0x2 gives 250 mV bias.
// RULE4: float start opens photodiode-to-receive-path switch.
// RULE5: amplifier input disconnected during float; output rests at reference.
// RULE6: integrator cleared immediately before positive phase.
// RULE7: software must not program a float interval below 4 us.
// RULE8: positive integration starts after integrator clear, photodiode still floating.
// RULE9: negative phase begins after positive phase, before reconnect.
// RULE10: photodiode reconnected during negative phase for charge dump, about 2 us.
// RULE11: after dump amplifier disconnected; negative phase then finishes.
// RULE12: integrator output held after negative phase until converter samples it.
// RULE13: whole dump lies inside negative phase; positive phase cancels offsets.
// RULE14: synchronous led pulse only between disconnect and reconnect.
// RULE15: both photodiode inputs summed into one channel.
// RULE16: operator checks linearity with half float time, expecting 2:1.
// RULE17: choose float timing for about half converter full scale.
// RULE18: event order strictly disconnect, clear, positive, negative, reconnect, release, hold.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module float_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        adc_sampled,
  output logic             pd_connect,
  output logic             amp_input_connect,
  output logic             bpf_bypass,
  output logic             pd_sum_enable,
  output logic             int_reset,
  output logic             int_positive,
  output logic             int_negative,
  output logic             int_hold,
  output logic             led_pulse,
  output logic [1:0]       amp_reference_select,
  output logic             cathode_override,
  output logic [1:0]       cathode_select,
  output logic             adc_request
);
  import float_seq_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] afe;
  logic [31:0] cathode;
  logic [15:0] t_float;
  logic [15:0] t_pos;
  logic [15:0] t_neg1;
  logic [15:0] t_dump;
  logic [15:0] t_neg2;
  logic        start_pulse;
  logic [31:0] status;

  seq_state_t  state_q;
  seq_state_t  state_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] flt_cnt_q;
  logic        short_q;
  logic        adc_s1_q;
  logic        adc_s2_q;
  logic        adc_s3_q;
  logic        adc_ack_q;
  logic        adc_seen_q;

  axil_regs u_regs (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .awaddr      (s_axi_awaddr),
    .awvalid     (s_axi_awvalid),
    .awready     (s_axi_awready),
    .wdata       (s_axi_wdata),
    .wstrb       (s_axi_wstrb),
    .wvalid      (s_axi_wvalid),
    .wready      (s_axi_wready),
    .bresp       (s_axi_bresp),
    .bvalid      (s_axi_bvalid),
    .bready      (s_axi_bready),
    .araddr      (s_axi_araddr),
    .arvalid     (s_axi_arvalid),
    .arready     (s_axi_arready),
    .rdata       (s_axi_rdata),
    .rresp       (s_axi_rresp),
    .rvalid      (s_axi_rvalid),
    .rready      (s_axi_rready),
    .status      (status),
    .start_pulse (start_pulse),
    .ctrl        (ctrl),
    .afe         (afe),
    .cathode     (cathode),
    .t_float     (t_float),
    .t_pos       (t_pos),
    .t_neg1      (t_neg1),
    .t_dump      (t_dump),
    .t_neg2      (t_neg2)
  );

  // ======================================================================
  // pin synchroniser for the converter's sample acknowledge
  // a level change counts only once stages two and three agree, so a runt is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_s1_q <= 1'b0;
      adc_s2_q <= 1'b0;
      adc_s3_q <= 1'b0;
      adc_ack_q <= 1'b0;
    end else begin
      adc_s1_q <= adc_sampled;
      adc_s2_q <= adc_s1_q;
      adc_s3_q <= adc_s2_q;
      adc_ack_q <= (adc_s2_q == adc_s3_q) ? adc_s3_q : adc_ack_q;
    end
  end

  // ======================================================================
  // sequencer
  wire float_mode = ctrl[CTRL_FLOAT_BIT];
  wire cnt_done   = cnt_q <= 16'h0001;
  // zero-length phases still take one cycle so no event is skipped
  function automatic logic [15:0] load(input logic [15:0] t);
    return (t == 16'h0000) ? 16'h0001 : t;
  endfunction
  // float is always at least the legal minimum even if software asks for less
  wire [15:0] float_len = (t_float < 16'(FLOAT_MIN_CYC)) ? 16'(FLOAT_MIN_CYC) : t_float;
  // output decodes; the float length counter below reads pd_connect_w
  wire floating_w   = state_q inside {S_FLOAT, S_INT_CLR, S_POS, S_NEG};
  wire pd_connect_w = !floating_w;
  wire amp_conn_w   = state_q inside {S_PRECON, S_DUMP};                 // see RULE5
  wire neg_w        = state_q inside {S_NEG, S_DUMP, S_TAIL};            // see RULE13
  wire led_w        = ctrl[CTRL_LED_BIT] && state_q inside {S_FLOAT, S_INT_CLR, S_POS};

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q - 16'h0001;
    unique case (state_q)
      S_PRECON: begin
        cnt_d = cnt_q;
        if (start_pulse && float_mode) begin
          state_d = S_FLOAT;                                   // see RULE4
          cnt_d   = 16'(float_len - t_pos - t_neg1 - 16'h0001);
          if (float_len <= 16'(t_pos + t_neg1 + 16'h0001)) begin
            cnt_d = 16'h0001;
          end
        end
      end
      S_FLOAT:   if (cnt_done) begin
        state_d = S_INT_CLR;                                   // see RULE18
        cnt_d   = 16'h0001;
      end
      S_INT_CLR: if (cnt_done) begin
        state_d = S_POS;                                       // see RULE6
        cnt_d   = load(t_pos);
      end
      S_POS:     if (cnt_done) begin
        state_d = S_NEG;                                       // see RULE9
        cnt_d   = load(t_neg1);
      end
      S_NEG:     if (cnt_done) begin
        state_d = S_DUMP;                                      // see RULE10
        cnt_d   = load(t_dump);
      end
      S_DUMP:    if (cnt_done) begin
        state_d = S_TAIL;                                      // see RULE11
        cnt_d   = load(t_neg2);
      end
      S_TAIL:    if (cnt_done) begin
        state_d = S_HOLD;                                      // see RULE12
        cnt_d   = 16'h0000;
      end
      S_HOLD: begin
        cnt_d = 16'h0000;
        if (adc_seen_q) begin
          state_d = S_PRECON;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q    <= S_PRECON;
      cnt_q      <= 16'h0000;
      flt_cnt_q  <= 16'h0000;
      short_q    <= 1'b0;
      adc_seen_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      adc_seen_q <= (state_q == S_HOLD) && adc_ack_q && !adc_seen_q;
      if (state_q == S_PRECON && state_d == S_FLOAT) begin
        flt_cnt_q <= 16'h0000;
        short_q   <= t_float < 16'(FLOAT_MIN_CYC);                 // see RULE7
      end else if (!pd_connect_w) begin
        flt_cnt_q <= flt_cnt_q + 16'h0001;
      end
    end
  end

  // ======================================================================
  // switch and integrator controls, registered outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_connect           <= 1'b1;
      amp_input_connect    <= 1'b1;
      bpf_bypass           <= 1'b0;
      pd_sum_enable        <= 1'b1;
      int_reset            <= 1'b0;
      int_positive         <= 1'b0;
      int_negative         <= 1'b0;
      int_hold             <= 1'b0;
      led_pulse            <= 1'b0;
      amp_reference_select <= 2'h0;
      cathode_override     <= 1'b0;
      cathode_select       <= 2'h0;
      adc_request          <= 1'b0;
    end else begin
      pd_connect           <= pd_connect_w;                            // see RULE2
      amp_input_connect    <= amp_conn_w;
      bpf_bypass           <= float_mode;                              // see RULE1
      pd_sum_enable        <= 1'b1;                                    // see RULE15
      int_reset            <= state_q == S_INT_CLR;
      int_positive         <= state_q == S_POS;                        // see RULE8
      int_negative         <= neg_w;
      int_hold             <= state_q == S_HOLD;
      led_pulse            <= led_w;                                   // see RULE14
      amp_reference_select <= afe[VREF_LSB +: 2];                      // see RULE2
      cathode_override     <= cathode[VCAT_EN_BIT];                    // see RULE3
      cathode_select       <= cathode[VCAT_A_LSB +: 2];                // see RULE3
      adc_request          <= state_q == S_HOLD && !adc_seen_q;
    end
  end

  assign status = {24'h00_0000, 1'b0, 3'(state_q), 1'b0, short_q,
                   int_hold, state_q != S_PRECON};

  // ======================================================================
  // checks
  chk_led_floating: assert property (@(posedge aclk) disable iff (!aresetn)
    led_pulse |-> !pd_connect) // see RULE14
    else $error("led fired while photodiode connected");

  chk_reset_then_pos: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(int_reset) |-> int_positive && !pd_connect) // see RULE6
    else $error("positive phase did not follow integrator clear");

  chk_pos_then_neg: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(int_positive) |-> int_negative && !pd_connect) // see RULE9
    else $error("negative phase did not follow positive phase");

  chk_dump_in_neg: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pd_connect) |-> int_negative && amp_input_connect) // see RULE10
    else $error("reconnect outside negative phase");

  chk_amp_float: assert property (@(posedge aclk) disable iff (!aresetn)
    !pd_connect |-> !amp_input_connect) // see RULE5
    else $error("amplifier connected while floating");

  chk_tail_release: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(amp_input_connect) && pd_connect |-> int_negative && !int_hold) // see RULE11
    else $error("negative phase ended at dump release");

  chk_hold_after_neg: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(int_negative) |-> int_hold) // see RULE12
    else $error("hold did not follow negative phase");

  chk_float_min: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pd_connect) |-> flt_cnt_q >= 16'(FLOAT_MIN_CYC)) // see RULE7
    else $error("float interval shorter than minimum");

  chk_bypass_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    !pd_connect |-> bpf_bypass) // see RULE1
    else $error("band-pass not bypassed in float");

  chk_pos_no_dump: assert property (@(posedge aclk) disable iff (!aresetn)
    int_positive |-> !pd_connect && !int_negative) // see RULE13
    else $error("charge dump during positive phase");

  chk_clear_single: assert property (@(posedge aclk) disable iff (!aresetn)
    int_reset |=> !int_reset && int_positive) // see RULE6
    else $error("integrator clear not one cycle before positive phase");

  chk_hold_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    int_hold |-> !int_positive && !int_negative && pd_connect) // see RULE12
    else $error("integrator not idle during hold");
endmodule
